// File: hw/secl_loader.sv
// serial eeprom configuration loader with apb register access
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "secl_params.svh"

module secl_loader #(
  parameter int unsigned PROG_CYCLES = `SECL_PROG_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_clock_pin,
  output logic eeprom_select_pin,
  output logic external_decode_select_pin,
  output logic pnp_active
);

  secl_pkg::secl_state_type state;
  secl_pkg::secl_req_type req;
  secl_pkg::secl_pins_type sh_pins;
  logic sh_start;
  logic sh_ready;
  logic sh_done;
  logic din_level;
  logic [31:0] sh_in;

  logic [`SECL_CMD_W-1:0] eeprom_command;
  logic [15:0] eeprom_data;
  logic checksum_good_flag;
  logic init_complete_flag;
  logic cfg_valid;
  logic big_part;
  logic pnp_off;
  logic [2:0] strap_cnt;
  logic [7:0] link;
  logic [7:0] sum;
  logic [7:0] ptr;
  logic [4:0] grp_left;
  logic [9:0] dest;
  logic [31:0] prog_cnt;
  logic [15:0] cfg_mem [0:`SECL_CFG_WORDS-1];

  logic wr_acc;
  logic cmd_take;
  logic data_take;
  logic [15:0] boot_word;
  logic [15:0] rd_word;
  logic [31:0] next_prdata;
  logic next_err;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] add_bytes(input logic [7:0] s, input logic [15:0] w);
    add_bytes = 8'(s + w[15:8] + w[7:0]);
  endfunction : add_bytes

  function automatic logic [1:0] ext_sel(input logic [7:0] a, input logic big);
    ext_sel = big ? a[7:6] : a[5:4];
  endfunction : ext_sel

  function automatic logic carries_data(input logic [1:0] op, input logic [1:0] ex);
    carries_data = (op == `SECL_OP_RD) || (op == `SECL_OP_WR) ||
                   (op == `SECL_OP_EXT && ex == `SECL_EX_WRAL);
  endfunction : carries_data

  function automatic logic needs_prog(input logic [1:0] op, input logic [1:0] ex);
    needs_prog = (op == `SECL_OP_WR) || (op == `SECL_OP_ER) ||
                 (op == `SECL_OP_EXT && (ex == `SECL_EX_ERAL || ex == `SECL_EX_WRAL));
  endfunction : needs_prog

  // start bit, opcode, six or eight address bits, optional data word
  function automatic secl_pkg::secl_req_type build_req(input logic [1:0] op,
      input logic [7:0] a, input logic big, input logic [15:0] d);
    secl_pkg::secl_req_type r;
    logic [5:0] abits;
    logic [1:0] ex;
    r = '0;
    ex = ext_sel(a, big);
    abits = big ? `SECL_ABITS_BIG : `SECL_ABITS_SMALL;
    if (big) begin
      r.bits = {1'b1, op, a, d, 5'h00};
    end else begin
      r.bits = {1'b1, op, a[5:0], d, 7'h00};
    end
    r.len = 6'(6'h03 + abits);
    if (carries_data(op, ex)) begin
      r.len = 6'(r.len + 6'(`SECL_DATA_W));
    end
    build_req = r;
  endfunction : build_req

  // ----------------------------------------------------------------------
  // serial engine
  // ----------------------------------------------------------------------
  secl_shift u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .start(sh_start),
    .req(req),
    .serial_in_pin(serial_in_pin),
    .pins(sh_pins),
    .ready(sh_ready),
    .done(sh_done),
    .din_level(din_level),
    .shift_in(sh_in)
  );

  assign sh_start = (state == secl_pkg::st_hdr) || (state == secl_pkg::st_rd) ||
                    (state == secl_pkg::st_cmd);

  // pins are re-timed so every output leaves from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_pin <= 1'b0;
      serial_clock_pin <= 1'b0;
      eeprom_select_pin <= 1'b0;
      external_decode_select_pin <= 1'b0;
    end else begin
      serial_out_pin <= sh_pins.dout;
      serial_clock_pin <= sh_pins.sk;
      eeprom_select_pin <= sh_pins.cs && !eeprom_command[`SECL_CS_BIT];
      external_decode_select_pin <= sh_pins.cs && eeprom_command[`SECL_CS_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // apb slave: answer prepared in setup, pready high in access
  // ----------------------------------------------------------------------
  assign wr_acc = psel && penable && pready && pwrite;
  assign cmd_take = wr_acc && (paddr == `SECL_CMD_ADDR) && (state == secl_pkg::st_idle);
  assign data_take = wr_acc && (paddr == `SECL_DATA_ADDR) && (state == secl_pkg::st_idle);
  assign rd_word = cfg_valid ? cfg_mem[paddr[10:2]] : 16'h0000;

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_err = 1'b0;
    if (paddr == `SECL_CMD_ADDR) begin
      next_prdata = {21'h000000, eeprom_command};
    end else if (paddr == `SECL_DATA_ADDR) begin
      next_prdata = {16'h0000, eeprom_data};
    end else if (paddr == `SECL_STAT_ADDR) begin
      next_prdata[`SECL_ST_CSUM] = checksum_good_flag;
      next_prdata[`SECL_ST_BUSY] = (state != secl_pkg::st_idle);
      next_prdata[`SECL_ST_INIT] = init_complete_flag;
      next_prdata[`SECL_ST_PNP] = pnp_active;
      next_prdata[`SECL_ST_CFG] = cfg_valid;
      next_prdata[`SECL_ST_BIG] = big_part;
      next_prdata[`SECL_ST_PNPOFF] = pnp_off;
    end else if ((paddr & `SECL_CFG_MASK) == `SECL_CFG_BASE) begin
      next_prdata = {16'h0000, rd_word};
    end else begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pready <= 1'b1;
      pslverr <= next_err;
    end else begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // host registers; writes while busy are dropped
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eeprom_command <= `SECL_CMD_RESET;
    end else if (cmd_take) begin
      eeprom_command <= pwdata[`SECL_CMD_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eeprom_data <= 16'h0000;
    end else if (state == secl_pkg::st_cmd_wait && sh_done &&
                 eeprom_command[`SECL_OP_HI:`SECL_OP_LO] == `SECL_OP_RD) begin
      eeprom_data <= sh_in[15:0];
    end else if (data_take) begin
      eeprom_data <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------------
  // configuration store; contents only count while the checksum held
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (state == secl_pkg::st_rd_wait && sh_done && ptr != {1'b0, link[7:1]} &&
        grp_left != 5'h00) begin
      cfg_mem[dest[9:1]] <= sh_in[15:0];
    end
  end

  // small parts put the word one bit earlier than large ones
  assign boot_word = sh_in[17] ? sh_in[15:0] : sh_in[16:1];

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= secl_pkg::st_strap;
      req <= '0;
      strap_cnt <= 3'h0;
      checksum_good_flag <= 1'b0;
      init_complete_flag <= 1'b0;
      cfg_valid <= 1'b0;
      big_part <= 1'b0;
      pnp_off <= 1'b0;
      link <= 8'h00;
      sum <= 8'h00;
      ptr <= 8'h00;
      grp_left <= 5'h00;
      dest <= 10'h000;
      prog_cnt <= 32'h0000_0000;
    end else begin
      case (state)
        secl_pkg::st_strap: begin
          // wait for the synchroniser to settle on the strap level
          strap_cnt <= strap_cnt + 3'h1;
          if (strap_cnt == `SECL_STRAP_WAIT) begin
            if (din_level) begin
              req <= build_req(`SECL_OP_RD, 8'h00, 1'b1, 16'h0000);
              state <= secl_pkg::st_hdr;
            end else begin
              init_complete_flag <= 1'b1;
              state <= secl_pkg::st_idle;
            end
          end
        end
        secl_pkg::st_hdr: begin
          if (sh_ready) begin
            state <= secl_pkg::st_hdr_wait;
          end
        end
        secl_pkg::st_hdr_wait: begin
          if (sh_done) begin
            big_part <= sh_in[17];
            if (boot_word[15:13] != `SECL_HDR_SIG) begin
              init_complete_flag <= 1'b1;
              state <= secl_pkg::st_idle;
            end else begin
              pnp_off <= boot_word[12];
              link <= boot_word[7:0];
              sum <= add_bytes(8'h00, boot_word);
              ptr <= 8'h01;
              grp_left <= 5'h00;
              req <= build_req(`SECL_OP_RD, 8'h01, sh_in[17], 16'h0000);
              state <= secl_pkg::st_rd;
            end
          end
        end
        secl_pkg::st_rd: begin
          if (sh_ready) begin
            state <= secl_pkg::st_rd_wait;
          end
        end
        secl_pkg::st_rd_wait: begin
          if (sh_done) begin
            if (ptr == {1'b0, link[7:1]}) begin
              if (8'(sum + sh_in[15:8]) == 8'h00) begin
                cfg_valid <= 1'b1;
                checksum_good_flag <= 1'b1;
              end else begin
                cfg_valid <= 1'b0;
                pnp_off <= 1'b0;
                checksum_good_flag <= 1'b0;
              end
              init_complete_flag <= 1'b1;
              state <= secl_pkg::st_idle;
            end else begin
              sum <= add_bytes(sum, sh_in[15:0]);
              if (grp_left == 5'h00) begin
                grp_left <= {1'b0, sh_in[15:12]} + 5'h01;
                dest <= sh_in[9:0];
              end else begin
                grp_left <= grp_left - 5'h01;
                dest <= 10'(dest + `SECL_REG_STEP);
              end
              ptr <= ptr + 8'h01;
              req <= build_req(`SECL_OP_RD, 8'(ptr + 8'h01), big_part, 16'h0000);
              state <= secl_pkg::st_rd;
            end
          end
        end
        secl_pkg::st_idle: begin
          if (cmd_take) begin
            // opcode and the part's six or eight low address bits go out as written
            req <= build_req(pwdata[`SECL_OP_HI:`SECL_OP_LO], pwdata[7:0], big_part,
                             eeprom_data);
            state <= secl_pkg::st_cmd;
          end
        end
        secl_pkg::st_cmd: begin
          if (sh_ready) begin
            state <= secl_pkg::st_cmd_wait;
          end
        end
        secl_pkg::st_cmd_wait: begin
          if (sh_done) begin
            prog_cnt <= 32'h0000_0000;
            // the part itself fills erased words with ones
            if (needs_prog(eeprom_command[`SECL_OP_HI:`SECL_OP_LO],
                           ext_sel(eeprom_command[7:0], big_part))) begin
              state <= secl_pkg::st_prog;
            end else begin
              state <= secl_pkg::st_idle;
            end
          end
        end
        secl_pkg::st_prog: begin
          // fixed worst-case wait instead of polling ready on data-in
          prog_cnt <= prog_cnt + 32'h0000_0001;
          if (prog_cnt == 32'(PROG_CYCLES - 1)) begin
            state <= secl_pkg::st_idle;
          end
        end
        default: begin
          state <= secl_pkg::st_idle;
        end
      endcase
    end
  end

  // plug-and-play only with a valid block that leaves it enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pnp_active <= 1'b0;
    end else begin
      pnp_active <= init_complete_flag && cfg_valid && !pnp_off;
    end
  end

endmodule : secl_loader
`default_nettype wire

// File: hw/secl_params.svh
// constants for the serial eeprom configuration loader
`ifndef SECL_PARAMS_SVH
`define SECL_PARAMS_SVH

// ----------------------------------------------------------------------
// register indices; byte address is four times the index
// ----------------------------------------------------------------------
`define SECL_CMD_IDX 16'h0040
`define SECL_DATA_IDX 16'h0042
`define SECL_STAT_IDX 16'h0136
`define SECL_CMD_ADDR (`SECL_CMD_IDX << 2)
`define SECL_DATA_ADDR (`SECL_DATA_IDX << 2)
`define SECL_STAT_ADDR (`SECL_STAT_IDX << 2)
`define SECL_CFG_BASE 16'h2000
`define SECL_CFG_MASK 16'he003

// ----------------------------------------------------------------------
// command register fields
// ----------------------------------------------------------------------
`define SECL_CMD_W 11
`define SECL_CMD_RESET 11'h000
`define SECL_CS_BIT 10
`define SECL_OP_HI 9
`define SECL_OP_LO 8
`define SECL_OP_RD 2'h2
`define SECL_OP_WR 2'h1
`define SECL_OP_ER 2'h3
`define SECL_OP_EXT 2'h0
`define SECL_EX_EWEN 2'h3
`define SECL_EX_EWDS 2'h0
`define SECL_EX_ERAL 2'h2
`define SECL_EX_WRAL 2'h1

// ----------------------------------------------------------------------
// status register bits
// ----------------------------------------------------------------------
`define SECL_ST_CSUM 10
`define SECL_ST_BUSY 8
`define SECL_ST_INIT 7
`define SECL_ST_PNP 3
`define SECL_ST_CFG 2
`define SECL_ST_BIG 1
`define SECL_ST_PNPOFF 0

// ----------------------------------------------------------------------
// configuration block layout
// ----------------------------------------------------------------------
`define SECL_HDR_SIG 3'h5
`define SECL_DATA_W 16
`define SECL_ABITS_BIG 6'h08
`define SECL_ABITS_SMALL 6'h06
`define SECL_CFG_WORDS 512
`define SECL_REG_STEP 10'h002

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SECL_CLK_KHZ 25000
`define SECL_SK_KHZ 1000
`define SECL_SK_HALF ((`SECL_CLK_KHZ + 2 * `SECL_SK_KHZ - 1) / (2 * `SECL_SK_KHZ))
`define SECL_PROG_MS 10
`define SECL_PROG_CYC (`SECL_PROG_MS * `SECL_CLK_KHZ)
`define SECL_STRAP_WAIT 3'h4

`endif

// File: hw/secl_pkg.sv
// types shared by the serial eeprom configuration loader
package secl_pkg;

  // one serial transfer: bit count and bits, msb first
  typedef struct packed {
    logic [5:0] len;
    logic [31:0] bits;
  } secl_req_type;

  typedef struct packed {
    logic sk;
    logic cs;
    logic dout;
  } secl_pins_type;

  typedef enum logic [3:0] {
    st_strap = 4'h0,
    st_hdr = 4'h1,
    st_hdr_wait = 4'h2,
    st_rd = 4'h3,
    st_rd_wait = 4'h4,
    st_idle = 4'h5,
    st_cmd = 4'h6,
    st_cmd_wait = 4'h7,
    st_prog = 4'h8
  } secl_state_type;

endpackage : secl_pkg

// File: hw/secl_shift.sv
// serial shift engine for the three-wire eeprom
`timescale 1ns/1ns
`default_nettype none
`include "secl_params.svh"

module secl_shift (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire secl_pkg::secl_req_type req,
  input wire logic serial_in_pin,
  output secl_pkg::secl_pins_type pins,
  output logic ready,
  output logic done,
  output logic din_level,
  output logic [31:0] shift_in
);

  logic s1;
  logic s2;
  logic s3;
  logic active;
  logic gap;
  logic [31:0] out_sr;
  logic [5:0] left;
  logic [4:0] hcnt;

  // ----------------------------------------------------------------------
  // input synchroniser; a change counts once stages two and three agree
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      din_level <= 1'b0;
    end else begin
      s1 <= serial_in_pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        din_level <= s3;
      end
    end
  end

  // select stays low a half period after each transfer
  assign ready = !active && !gap;

  // ----------------------------------------------------------------------
  // shifter: data changes with sk low, input taken on the rising edge
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active <= 1'b0;
      gap <= 1'b0;
      out_sr <= 32'h0000_0000;
      left <= 6'h00;
      hcnt <= 5'h00;
      pins <= '0;
      done <= 1'b0;
      shift_in <= 32'h0000_0000;
    end else begin
      done <= 1'b0;
      if (start && ready) begin
        active <= 1'b1;
        out_sr <= req.bits;
        left <= req.len;
        hcnt <= 5'h00;
        pins.cs <= 1'b1;
        pins.sk <= 1'b0;
        pins.dout <= req.bits[31];
      end else if (active || gap) begin
        if (hcnt == 5'(`SECL_SK_HALF - 1)) begin
          hcnt <= 5'h00;
          if (gap) begin
            gap <= 1'b0;
          end else if (!pins.sk) begin
            if (left == 6'h00) begin
              active <= 1'b0;
              gap <= 1'b1;
              pins.cs <= 1'b0;
              pins.dout <= 1'b0;
              done <= 1'b1;
            end else begin
              pins.sk <= 1'b1;
              shift_in <= {shift_in[30:0], din_level};
              left <= left - 6'h01;
            end
          end else begin
            pins.sk <= 1'b0;
            out_sr <= {out_sr[30:0], 1'b0};
            pins.dout <= out_sr[30];
          end
        end else begin
          hcnt <= hcnt + 5'h01;
        end
      end
    end
  end

endmodule : secl_shift
`default_nettype wire

// File: dv/secl_eeprom_model.sv
// behavioural three-wire eeprom with 8-bit word addresses
`timescale 1ns/1ns
`default_nettype none
module secl_eeprom_model (
  input wire logic sk,
  input wire logic cs,
  input wire logic di,
  output logic dout
);
  // --------
  // storage and shift state
  // --------
  logic [15:0] mem [256];
  logic [15:0] rdw;
  logic [26:0] sh;
  logic [9:0] op;
  logic ewen = 1'b0;
  int n = 0;
  // a released line reads high through its pull-up
  initial dout = 1'b1;
  initial foreach (mem[i]) mem[i] = 16'hffff;
  always @(posedge cs) n = 0;
  always @(posedge sk) if (cs) begin
    sh = {sh[25:0], di};
    n++;
    if (n == 11) op = sh[9:0];
    if (n == 11) rdw = mem[sh[7:0]];
    dout = (n > 10 && n < 27 && op[9:8] == 2'h2) ? rdw[26 - n] : 1'b1;
  end
  // commands act when select drops; writes need the enable latch
  always @(negedge cs) begin
    dout = 1'b1;
    if (n == 11 && op[9:6] == 4'h3) ewen = 1'b1;
    if (n == 11 && op[9:6] == 4'h0) ewen = 1'b0;
    if (ewen && n == 11 && op[9:8] == 2'h3) mem[op[7:0]] = 16'hffff;
    if (ewen && n == 27 && op[9:8] == 2'h1) mem[op[7:0]] = sh[15:0];
    for (int i = 0; i < 256; i++) begin
      if (ewen && n == 11 && op[9:6] == 4'h2) mem[i] = 16'hffff;
      if (ewen && n == 27 && op[9:6] == 4'h1) mem[i] = sh[15:0];
    end
  end
endmodule : secl_eeprom_model
`default_nettype wire

// File: dv/secl_loader_asserts.sv
// port checks for the serial eeprom configuration loader
`timescale 1ns/1ns
`default_nettype none
module secl_loader_asserts #(
  parameter int unsigned PROG_CYCLES = 50
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_out_pin,
  input wire logic serial_clock_pin,
  input wire logic eeprom_select_pin,
  input wire logic external_decode_select_pin
);
  // --------
  // serial clock rises counted per frame
  // --------
  logic sel;
  logic sk_q;
  logic [5:0] nr;
  assign sel = eeprom_select_pin | external_decode_select_pin;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sk_q <= 1'b0;
      nr <= 6'h00;
    end else begin
      sk_q <= serial_clock_pin;
      nr <= sel ? nr + {5'h00, serial_clock_pin & !sk_q} : 6'h00;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence one_access;
    pready ##1 !pready;
  endsequence
  apb_answer_a: assert property (apb_setup |=> one_access)
    else $error("apb answer timing");
  rd_idle_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data outside access");
  sel_excl_a: assert property (!(eeprom_select_pin && external_decode_select_pin))
    else $error("both selects high");
  sk_idle_a: assert property (!sel |-> !serial_clock_pin)
    else $error("serial clock outside frame");
  start_bit_a: assert property ($rose(sel) |-> serial_out_pin)
    else $error("missing start bit");
  dout_hold_a: assert property (serial_clock_pin && $past(serial_clock_pin) |-> $stable(serial_out_pin))
    else $error("data moved while clock high");
  frame_len_a: assert property ($fell(sel) |-> nr == 6'h0b || nr == 6'h1b)
    else $error("bad frame length");
  sel_gap_a: assert property ($fell(sel) |=> !sel [*8])
    else $error("select gap too short");
endmodule : secl_loader_asserts
`default_nettype wire

// File: dv/tb_serial_eeprom_config_loader.sv
// testbench for the serial eeprom configuration loader
`timescale 1ns/1ns
`default_nettype none
`include "secl_params.svh"
module tb_serial_eeprom_config_loader;
  // --------
  // signals and bench state
  // --------
  logic pclk, presetn, psel, penable, pwrite, pull, pready, pslverr, sdo, sk, ecs, xcs, pnp, mdo;
  logic er;
  logic [7:0] a;
  logic [15:0] paddr, d;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] img [7];
  int mismatches, n_compared;
  secl_loader #(.PROG_CYCLES(50)) dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_pin(mdo & pull), .serial_out_pin(sdo), .serial_clock_pin(sk),
    .eeprom_select_pin(ecs), .external_decode_select_pin(xcs), .pnp_active(pnp));
  secl_eeprom_model eep (.sk(sk), .cs(ecs), .di(sdo), .dout(mdo));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // --------
  // bus tasks and expectations
  // --------
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [15:0] ad, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 99);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 99) begin
      mismatches++;
      stop_test();
    end
  endtask : apb
  task automatic chk(input logic [15:0] ad, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    cmp(rd & m, e);
  endtask : chk
  task automatic wait_idle;
    for (int k = 0; k < 4000; k++) begin
      apb(1'b0, `SECL_STAT_ADDR, 32'h0);
      if (rd[`SECL_ST_BUSY] === 1'b0) return;
    end
    mismatches++;
    stop_test();
  endtask : wait_idle
  task automatic cmd(input logic [10:0] c);
    apb(1'b1, `SECL_CMD_ADDR, {21'h0, c});
    wait_idle();
  endtask : cmd
  task automatic eread(input logic [7:0] ad, input logic [15:0] e);
    cmd({3'h2, ad});
    chk(`SECL_DATA_ADDR, 32'hffffffff, {16'h0, e});
  endtask : eread
  // the strap is sampled a few cycles after release, so busy is read late
  task automatic boot(input logic p);
    presetn <= 1'b0;
    pull <= p;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    wait_idle();
  endtask : boot
  function automatic logic [31:0] stat(input logic ok, input logic off);
    return {21'h0, ok, 3'h1, 3'h0, ok & !off, ok, 1'b0, ok & off};
  endfunction : stat
  function automatic logic [7:0] csum();
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 6; i++) s = s + img[i][15:8] + img[i][7:0];
    return 8'h00 - s;
  endfunction : csum
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pull = 1'b1;
    mismatches = 0;
    n_compared = 0;
    void'($urandom(92));
    @(posedge pclk);
    img = '{16'hb00c, 16'h1d58, 16'($urandom), 16'($urandom), 16'h0360, 16'($urandom), 16'h0};
    img[6] = {csum(), 8'h00};
    for (int i = 0; i < 7; i++) eep.mem[i] = img[i];
    boot(1'b1);
    chk(`SECL_STAT_ADDR, 32'h58d, stat(1'b1, 1'b1));
    cmp({31'h0, pnp}, 32'h0);
    apb(1'b0, 16'h0200, 32'h0);
    cmp({31'h0, er}, 32'h1);
    cmp(rd, 32'h0);
    chk(16'h22b4, 32'hffffffff, {16'h0, img[3]});
    chk(16'h26c0, 32'hffffffff, {16'h0, img[5]});
    $display("boot test done");
    for (int j = 0; j < 3; j++) begin
      a = 8'h10 + 8'($urandom % 200);
      d = 16'($urandom) & 16'h7fff;
      cmd(11'h0c0);
      apb(1'b1, `SECL_DATA_ADDR, {16'h0, d});
      cmd({3'h1, a});
      cmd(11'h000);
      eread(a, d);
      cmd({3'h6, a});
      chk(`SECL_DATA_ADDR, 32'hffffffff, 32'hffff);
      cmd(11'h0c0);
      cmd({3'h3, a});
      eread(a, 16'hffff);
      cmd(11'h000);
    end
    $display("command test done");
    cmd(11'h0c0);
    apb(1'b1, `SECL_DATA_ADDR, {16'h0, img[2] ^ 16'h0001});
    cmd(11'h102);
    cmd(11'h000);
    boot(1'b1);
    chk(`SECL_STAT_ADDR, 32'h58d, stat(1'b0, 1'b1));
    chk(16'h22b4, 32'hffffffff, 32'h0);
    cmd(11'h0c0);
    apb(1'b1, `SECL_DATA_ADDR, {16'h0, d});
    cmd(11'h040);
    eread(8'h05, d);
    cmd(11'h080);
    eread(a, 16'hffff);
    cmd(11'h000);
    boot(1'b1);
    chk(`SECL_STAT_ADDR, 32'h58d, stat(1'b0, 1'b0));
    img[0][12] = 1'b0;
    img[6] = {csum(), 8'h00};
    for (int i = 0; i < 7; i++) eep.mem[i] = img[i];
    boot(1'b0);
    chk(`SECL_STAT_ADDR, 32'h58d, stat(1'b0, 1'b0));
    cmp({31'h0, pnp}, 32'h0);
    boot(1'b1);
    chk(`SECL_STAT_ADDR, 32'h58d, stat(1'b1, 1'b0));
    cmp({31'h0, pnp}, 32'h1);
    $display("fault and strap tests done");
    stop_test();
  end
endmodule : tb_serial_eeprom_config_loader
bind secl_loader secl_loader_asserts #(.PROG_CYCLES(PROG_CYCLES)) chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serial_out_pin(serial_out_pin),
  .serial_clock_pin(serial_clock_pin), .eeprom_select_pin(eeprom_select_pin),
  .external_decode_select_pin(external_decode_select_pin));
`default_nettype wire
